//--- rtl/rcc_map.svh
// Constant map of the reset and clock control block
`ifndef RCC_MAP_SVH
`define RCC_MAP_SVH
// ---------------------------------------------------------------------
// Configuration register layout and reset value
// ---------------------------------------------------------------------
`define RCC_CFG_RESET 16'h0008
`define RCC_DIV_SEL_HI 9
`define RCC_DIV_SEL_LO 8
`define RCC_EDGE_SEL_HI 3
`define RCC_EDGE_SEL_LO 2
// ---------------------------------------------------------------------
// Divisor codes and edge modes
// ---------------------------------------------------------------------
`define RCC_DIV_3P0 2'h0
`define RCC_DIV_2P5 2'h1
`define RCC_DIV_2P0 2'h2
`define RCC_DIV_1P5 2'h3
`define RCC_EDGE_OFF 2'h0
`define RCC_EDGE_RISE 2'h1
`define RCC_EDGE_FALL 2'h2
`define RCC_EDGE_ANY 2'h3
// ---------------------------------------------------------------------
// Reset vectors, mask level and timing
// ---------------------------------------------------------------------
`define RCC_VEC_STACK_ADDR 24'h000000
`define RCC_VEC_PC_ADDR 24'h000004
`define RCC_MASK_LEVEL 3'h7
`define RCC_XTAL_DIV 2
`define RCC_STARTUP_CYCLES 8'h10
`define RCC_EXT_RESET_MIN_MS 100
`endif

//--- rtl/rcc_pkg.sv
// Types shared by the reset and clock control block
package rcc_pkg;
  // Reset sequencer states, Gray coded along the path
  typedef enum logic [2:0] {
    RCC_ST_RESET = 3'h0,
    RCC_ST_START = 3'h1,
    RCC_ST_FETCH = 3'h3,
    RCC_ST_MASK = 3'h2,
    RCC_ST_RUN = 3'h6
  } rcc_state_e;

  // Vector fetch request towards memory
  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } rcc_fetch_s;

  // Loaded CPU start context
  typedef struct packed {
    logic [31:0] supervisor_stack_pointer;
    logic [31:0] pc;
    logic [2:0] mask;
  } rcc_ctx_s;
endpackage

//--- rtl/rcc_top.sv
// Reset and clock control: reset merge, vector fetch, clock dividers
`timescale 1ns/1ps
`include "rcc_map.svh"
module rcc_top (
  // Clock and block reset
  input wire logic clk_sys,
  input wire logic reset,
  // Reset sources
  input wire logic ext_reset_pin,
  input wire logic por_pin,
  input wire logic wdt_overflow,
  input wire logic sw_reset,
  // Configuration register access
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // Watchdog enable control
  input wire logic wdt_enable_set,
  output logic wdt_enable,
  // Vector fetch port
  output rcc_pkg::rcc_fetch_s fetch,
  input wire logic fetch_ack,
  input wire logic [15:0] fetch_data,
  // CPU start context and resets
  output rcc_pkg::rcc_ctx_s cpu_ctx,
  output logic cpu_reset,
  output logic periph_reset,
  output logic cpu_run,
  // Clock enables and timer 0
  output logic int_clk_en,
  output logic base_peripheral_clock,
  input wire logic timer0_ext_in,
  output logic timer0_inc
);
  // ---------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------
  // Crystal cycles per peripheral pulse minus one
  function automatic logic [2:0] div_last(input logic [1:0] sel);
    case (sel)
      `RCC_DIV_3P0: div_last = 3'h5;
      `RCC_DIV_2P5: div_last = 3'h4;
      `RCC_DIV_2P0: div_last = 3'h3;
      default: div_last = 3'h2;
    endcase
  endfunction
  // ---------------------------------------------------------------------
  // Synchronisers and machine cycle
  // ---------------------------------------------------------------------
  logic ext_s1_r, ext_s2_r, por_s1_r, por_s2_r, t0_s1_r, t0_s2_r, t0_prev_r;
  logic ext_smp_r, ext_smp_nxt, mc_r, mc_nxt, glob_r, glob_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [1:0] div_sel, edge_sel;

  assign div_sel = cfg_r[`RCC_DIV_SEL_HI:`RCC_DIV_SEL_LO];
  assign edge_sel = cfg_r[`RCC_EDGE_SEL_HI:`RCC_EDGE_SEL_LO];

  // Machine cycle enable and reset merge
  always_comb begin
    mc_nxt = ~mc_r;
    ext_smp_nxt = mc_r ? ext_s2_r : ext_smp_r;
    glob_nxt = ext_smp_r | por_s2_r | wdt_overflow;
  end

  // Two-stage synchronisers, then sampled levels
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      por_s1_r <= 1'b1;
      por_s2_r <= 1'b1;
      t0_s1_r <= 1'b0;
      t0_s2_r <= 1'b0;
      t0_prev_r <= 1'b0;
      ext_smp_r <= 1'b1;
      mc_r <= 1'b0;
      glob_r <= 1'b1;
    end else begin
      ext_s1_r <= ext_reset_pin;
      ext_s2_r <= ext_s1_r;
      por_s1_r <= por_pin;
      por_s2_r <= por_s1_r;
      t0_s1_r <= timer0_ext_in;
      t0_s2_r <= t0_s1_r;
      t0_prev_r <= t0_s2_r;
      ext_smp_r <= ext_smp_nxt;
      mc_r <= mc_nxt;
      glob_r <= glob_nxt;
    end
  end

  assign int_clk_en = mc_r;
  // ---------------------------------------------------------------------
  // Configuration, watchdog enable, prescaler, timer 0 edges
  // ---------------------------------------------------------------------
  logic wdt_en_r, wdt_en_nxt, bp_r, bp_nxt, inc_r, inc_nxt;
  logic [2:0] pcnt_r, pcnt_nxt;
  // Next values of the peripheral side
  always_comb begin
    cfg_nxt = cfg_wr ? cfg_wdata : cfg_r;
    wdt_en_nxt = wdt_en_r | wdt_enable_set;
    if (glob_r || sw_reset) begin
      cfg_nxt = `RCC_CFG_RESET;
      wdt_en_nxt = 1'b0;
    end
    // Crystal-cycle count gives alternating 2/3 internal cycles for 2.5
    if (glob_r || pcnt_r >= div_last(div_sel)) begin
      pcnt_nxt = 3'h0;
    end else begin
      pcnt_nxt = pcnt_r + 3'h1;
    end
    bp_nxt = !glob_r && pcnt_r >= div_last(div_sel);
    case (edge_sel)
      `RCC_EDGE_RISE: inc_nxt = t0_s2_r & ~t0_prev_r;
      `RCC_EDGE_FALL: inc_nxt = ~t0_s2_r & t0_prev_r;
      `RCC_EDGE_ANY: inc_nxt = t0_s2_r ^ t0_prev_r;
      default: inc_nxt = 1'b0;
    endcase
  end

  // Peripheral side registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_r <= `RCC_CFG_RESET;
      wdt_en_r <= 1'b0;
      pcnt_r <= 3'h0;
      bp_r <= 1'b0;
      inc_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      wdt_en_r <= wdt_en_nxt;
      pcnt_r <= pcnt_nxt;
      bp_r <= bp_nxt;
      inc_r <= inc_nxt;
    end
  end

  assign cfg_rdata = cfg_r;
  assign wdt_enable = wdt_en_r;
  assign base_peripheral_clock = bp_r;
  assign timer0_inc = inc_r;
  // ---------------------------------------------------------------------
  // Reset sequencer and vector fetch
  // ---------------------------------------------------------------------
  rcc_pkg::rcc_state_e st_r, st_nxt;
  logic [7:0] scnt_r, scnt_nxt;
  logic [1:0] widx_r, widx_nxt;
  rcc_pkg::rcc_ctx_s ctx_r, ctx_nxt;
  logic prst_r, prst_nxt;
  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    scnt_nxt = scnt_r;
    widx_nxt = widx_r;
    ctx_nxt = ctx_r;
    prst_nxt = glob_r | sw_reset;
    case (st_r)
      rcc_pkg::RCC_ST_RESET: begin
        scnt_nxt = 8'h0;
        widx_nxt = 2'h0;
        if (!glob_r) begin
          st_nxt = rcc_pkg::RCC_ST_START;
        end
      end
      rcc_pkg::RCC_ST_START: begin
        scnt_nxt = scnt_r + 8'h1;
        if (scnt_r == `RCC_STARTUP_CYCLES - 8'h1) begin
          st_nxt = rcc_pkg::RCC_ST_FETCH;
        end
      end
      rcc_pkg::RCC_ST_FETCH: begin
        if (fetch_ack) begin
          case (widx_r)
            2'h0: ctx_nxt.supervisor_stack_pointer[31:16] = fetch_data;
            2'h1: ctx_nxt.supervisor_stack_pointer[15:0] = fetch_data;
            2'h2: ctx_nxt.pc[31:16] = fetch_data;
            default: ctx_nxt.pc[15:0] = fetch_data;
          endcase
          widx_nxt = widx_r + 2'h1;
          if (widx_r == 2'h3) begin
            st_nxt = rcc_pkg::RCC_ST_MASK;
          end
        end
      end
      rcc_pkg::RCC_ST_MASK: begin
        ctx_nxt.mask = `RCC_MASK_LEVEL;
        st_nxt = rcc_pkg::RCC_ST_RUN;
      end
      rcc_pkg::RCC_ST_RUN: begin
        st_nxt = rcc_pkg::RCC_ST_RUN;
      end
      default: begin
        st_nxt = rcc_pkg::RCC_ST_RESET;
      end
    endcase
    if (glob_r) begin
      st_nxt = rcc_pkg::RCC_ST_RESET;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= rcc_pkg::RCC_ST_RESET;
      scnt_r <= 8'h0;
      widx_r <= 2'h0;
      ctx_r <= '0;
      prst_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      scnt_r <= scnt_nxt;
      widx_r <= widx_nxt;
      ctx_r <= ctx_nxt;
      prst_r <= prst_nxt;
    end
  end

  // Fetch port and reset outputs
  assign fetch.req = (st_r == rcc_pkg::RCC_ST_FETCH);
  assign fetch.addr = `RCC_VEC_STACK_ADDR + {21'h0, widx_r, 1'b0};
  assign cpu_ctx = ctx_r;
  assign cpu_run = (st_r == rcc_pkg::RCC_ST_RUN);
  assign cpu_reset = (st_r != rcc_pkg::RCC_ST_RUN);
  assign periph_reset = prst_r;
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_cfg_after_glob;
    glob_r |=> cfg_r == `RCC_CFG_RESET;
  endproperty
  a_cfg_after_glob: assert property (p_cfg_after_glob) else $error("cfg not reset");
  // Divisor 2.5: a pulse, four quiet cycles, then the next pulse
  property p_div_pulse;
    bp_r && div_sel == `RCC_DIV_2P5 && !glob_r && !cfg_wr && !sw_reset
      ##1 (!glob_r && !cfg_wr && !sw_reset) [*4]
      |-> !bp_r && !$past(bp_r) && !$past(bp_r, 2) && !$past(bp_r, 3) ##1 bp_r;
  endproperty
  a_div_pulse: assert property (p_div_pulse) else $error("bad peripheral pulse spacing");
  property p_edge_off;
    edge_sel == `RCC_EDGE_OFF |=> !timer0_inc;
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("edge counted while off");
  property p_wdt_merge;
    wdt_overflow |-> ##2 cpu_reset && periph_reset;
  endproperty
  a_wdt_merge: assert property (p_wdt_merge) else $error("watchdog did not reset");
  property p_stack_first;
    st_r == rcc_pkg::RCC_ST_START ##1 st_r == rcc_pkg::RCC_ST_FETCH
      |-> fetch.req && fetch.addr == `RCC_VEC_STACK_ADDR;
  endproperty
  a_stack_first: assert property (p_stack_first) else $error("fetch not at zero");
  property p_pc_word;
    fetch.req && widx_r == 2'h2 |-> fetch.addr == `RCC_VEC_PC_ADDR;
  endproperty
  a_pc_word: assert property (p_pc_word) else $error("pc vector address wrong");
  property p_mask_run;
    st_r == rcc_pkg::RCC_ST_MASK && !glob_r |=> cpu_run && cpu_ctx.mask == `RCC_MASK_LEVEL;
  endproperty
  a_mask_run: assert property (p_mask_run) else $error("mask not 7 at run");
  property p_wdt_off;
    glob_r || sw_reset |=> !wdt_enable;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog still enabled");
  property p_sw_cpu;
    cpu_run && sw_reset && !glob_r |=> cpu_run && periph_reset;
  endproperty
  a_sw_cpu: assert property (p_sw_cpu) else $error("software reset hit cpu");
  property p_half;
    int_clk_en |=> !int_clk_en ##1 int_clk_en;
  endproperty
  a_half: assert property (p_half) else $error("internal clock not half rate");
  c_boot: cover property (st_r == rcc_pkg::RCC_ST_MASK ##1 cpu_run);
  c_rise: cover property (edge_sel == `RCC_EDGE_RISE && timer0_inc);
  c_sw: cover property (cpu_run && sw_reset);
  c_div15: cover property (div_sel == `RCC_DIV_1P5 && base_peripheral_clock);
endmodule

//--- sim/rcc_partner.sv
// Partner model: vector memory and external reset network of the block
`timescale 1ns/1ps
module rcc_partner #(
  parameter int HOLD = 40
) (
  // Clock and controls from the bench
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [63:0] vec,
  input wire logic pin_go,
  input wire logic por_go,
  // Vector fetch port
  input wire rcc_pkg::rcc_fetch_s fetch,
  output logic fetch_ack = 1'b0,
  output logic [15:0] fetch_data = 16'h0000,
  // Reset sources
  output logic ext_reset_pin,
  output logic por_pin
);
  int wait_c = 0;
  int hold_c = 0;
  logic use_por = 1'b0;

  // Answer each word once; data inverts whenever no answer is given
  always @(posedge clk_sys) begin
    fetch_ack <= 1'b0;
    fetch_data <= ~fetch_data;
    if (fetch.req && !fetch_ack) begin
      if (wait_c >= (slow ? 3 : 0)) begin
        fetch_ack <= 1'b1;
        fetch_data <= vec[63 - 16 * fetch.addr[2:1] -: 16];
        wait_c <= 0;
      end else begin
        wait_c <= wait_c + 1;
      end
    end
  end

  // Hold one reset source high for a scaled number of cycles
  always @(posedge clk_sys) begin
    if (pin_go || por_go) begin
      hold_c <= HOLD;
      use_por <= por_go;
    end else if (hold_c > 0) begin
      hold_c <= hold_c - 1;
    end
  end
  assign ext_reset_pin = (hold_c > 0) && !use_por;
  assign por_pin = (hold_c > 0) && use_por;
endmodule

//--- sim/tb.sv
// Self-checking bench of the reset and clock control block
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic wdt_overflow = 1'b0;
  logic sw_reset = 1'b0;
  logic cfg_wr = 1'b0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic wdt_enable_set = 1'b0;
  logic timer0_ext_in = 1'b0;
  logic slow = 1'b0;
  logic pin_go = 1'b0;
  logic por_go = 1'b0;
  logic [63:0] vec = 64'h0;
  logic ext_reset_pin, por_pin, fetch_ack, cpu_reset, periph_reset, cpu_run;
  logic int_clk_en, base_peripheral_clock, timer0_inc, wdt_enable;
  logic [15:0] fetch_data, cfg_rdata;
  rcc_pkg::rcc_fetch_s fetch;
  rcc_pkg::rcc_ctx_s cpu_ctx;
  int mismatches = 0;
  int num_checks = 0;
  int cnt_int = 0;
  int cnt_bpc = 0;
  int cnt_t0 = 0;
  int d;

  rcc_top i_rcc_top (.clk_sys(clk_sys), .reset(reset), .ext_reset_pin(ext_reset_pin),
    .por_pin(por_pin), .wdt_overflow(wdt_overflow), .sw_reset(sw_reset), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .wdt_enable_set(wdt_enable_set),
    .wdt_enable(wdt_enable), .fetch(fetch), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .cpu_ctx(cpu_ctx), .cpu_reset(cpu_reset), .periph_reset(periph_reset),
    .cpu_run(cpu_run), .int_clk_en(int_clk_en),
    .base_peripheral_clock(base_peripheral_clock), .timer0_ext_in(timer0_ext_in),
    .timer0_inc(timer0_inc));
  rcc_partner i_rcc_partner (.clk_sys(clk_sys), .slow(slow), .vec(vec), .pin_go(pin_go),
    .por_go(por_go), .fetch(fetch), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .ext_reset_pin(ext_reset_pin), .por_pin(por_pin));

  // 125 MHz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Pulse counters of the clock enables and timer output
  always @(posedge clk_sys) begin
    cnt_int <= cnt_int + (int_clk_en === 1'b1);
    cnt_bpc <= cnt_bpc + (base_peripheral_clock === 1'b1);
    cnt_t0 <= cnt_t0 + (timer0_inc === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int exp_t0(input logic [1:0] code, input int n);
    return (code == 2'h0) ? 0 : (code == 2'h3) ? n : n / 2;
  endfunction

  task automatic wr_cfg(input logic [15:0] w);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_wdata <= w;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask

  // Wait for run, then compare the loaded start context
  task automatic boot();
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(n < 400, 1'b1);
    chk(cpu_ctx.supervisor_stack_pointer, vec[63:32]);
    chk(cpu_ctx.pc, vec[31:0]);
    chk(cpu_ctx.mask, 3'h7);
    chk(cpu_reset, 1'b0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog: the tests need about a thousand cycles, allow about 25000
  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [15:0] w;
    void'($urandom(93));
    vec = {$urandom, $urandom};
    tick(8);
    reset <= 1'b0;
    tick(1);
    chk(cfg_rdata, 16'h0008);
    chk(cpu_reset, 1'b1);
    boot();
    d = cnt_int;
    tick(60);
    chk(cnt_int - d, 30);
    // Every divisor and edge code, other bits random
    for (int c = 0; c < 4; c++) begin
      w = 16'($urandom);
      w[9:8] = c[1:0];
      w[3:2] = c[1:0];
      wr_cfg(w);
      tick(12);
      chk(cfg_rdata[9:8], c);
      chk(cfg_rdata[3:2], c);
      d = cnt_bpc;
      tick(60);
      chk(cnt_bpc - d, 60 / (6 - c));
      d = cnt_t0;
      for (int t = 0; t < 6; t++) begin
        @(posedge clk_sys);
        timer0_ext_in <= ~timer0_ext_in;
        tick(8 + $urandom % 8);
      end
      chk(cnt_t0 - d, exp_t0(c, 6));
    end
    // Watchdog overflow in mid-run, then reboot with a slow memory
    @(posedge clk_sys);
    wdt_enable_set <= 1'b1;
    @(posedge clk_sys);
    wdt_enable_set <= 1'b0;
    tick(1);
    chk(wdt_enable, 1'b1);
    wdt_overflow <= 1'b1;
    @(posedge clk_sys);
    wdt_overflow <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({cpu_reset, periph_reset, wdt_enable}, 3'h6);
    slow <= 1'b1;
    vec = {$urandom, $urandom};
    boot();
    chk(cfg_rdata, 16'h0008);
    // Software reset leaves the running processor alone
    wr_cfg(16'h0300);
    @(posedge clk_sys);
    wdt_enable_set <= 1'b1;
    @(posedge clk_sys);
    wdt_enable_set <= 1'b0;
    sw_reset <= 1'b1;
    @(posedge clk_sys);
    sw_reset <= 1'b0;
    #1;
    chk({periph_reset, cpu_run}, 2'h3);
    chk(cpu_ctx.pc, vec[31:0]);
    chk(cfg_rdata, 16'h0008);
    tick(2);
    chk(wdt_enable, 1'b0);
    // Pin reset and power-on reset through the reset network
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      pin_go <= (k == 0);
      por_go <= (k == 1);
      @(posedge clk_sys);
      pin_go <= 1'b0;
      por_go <= 1'b0;
      vec = {$urandom, $urandom};
      tick(8);
      chk({cpu_reset, periph_reset, cpu_run}, 3'h6);
      boot();
    end
    conclude();
  end
endmodule
